// File: inc/phy_ctrl_consts.vh
// Constants for the transceiver mode, indicator and interrupt control block
// Functional notes
// (R1) Basic-mode indicator reduction on led bit 5; config-two bit 0 picks variant.
// (R2) Low-speed lamp: 10M link; reduced sel0 any link plus activity; sel1 link.
// (R3) Three-in-one keeps gigabit link, activity and duplex lamps standard.
// (R4) Activity lamp is steadily lit while transmit or receive activity exists.
// (R5) Led bits 3 and 4 make idle or CRC errors blink activity faster.
// (R6) Exactly one MAC-side interface type is active at a time; the code selects none in isolate, soft reset or speed 11 without RGMII.
// (R7) Forced speed 00/01 give MII, 10 gives GMII/RGMII, 11 reserved.
// (R8) Negotiated 10/100 gives MII, negotiated 1000 gives GMII/RGMII.
// (R9) Straps: select_lo 0 with select_hi 1 first RGMII variant, both 1 second.
// (R10) Auxiliary bits 13:12 at 10 or 11 enable RGMII, disabling GMII and MII.
// (R11) One strap enables the MAC clock, another picks 25 or 125 MHz.
// (R12) MAC clock only after reset and init finish; may stop in soft reset.
// (R13) Basic control bit 10 isolates the MAC-side interface.
// (R14) 10/100 isolate ignores transmit inputs, floats outputs, keeps management.
// (R15) Gigabit isolate floats outputs, powers down, halts medium access.
// (R16) Basic control bit 14 loops transmit data to receive, none to media.
// (R17) Loopback data passes the coding path before returning to receive.
// (R18) Gigabit control 15:13 selects test modes 1..4, 000 normal.
// (R19) Test clock, trigger and aux clock need auxiliary bits 6 and 7.
// (R20) Reset disables the interrupt and clears flags and enables.
// (R21) Interrupt is active low, held until cleared, floated otherwise.
// (R22) Enabled flag asserts interrupt; writing one to acknowledge clears it.
`ifndef PHY_CTRL_CONSTS_VH
`define PHY_CTRL_CONSTS_VH
// ==========================================================
// Register addresses (management frame register field)
`define REG_BASIC 5'h00
`define REG_GIGCTL 5'h09
`define REG_AUX 5'h12
`define REG_LED 5'h13
`define REG_FLAGS 5'h14
`define REG_ENABLES 5'h15
`define REG_ACK 5'h17
`define REG_CFG2 5'h1a
// ==========================================================
// Reset values
`define BASIC_RST 16'h1140
`define ZERO16 16'h0000
// ==========================================================
// Field positions
`define BC_SOFTRST 15
`define BC_LOOP 14
`define BC_SPD_LSB 13
`define BC_AN_EN 12
`define BC_PDOWN 11
`define BC_ISOLATE 10
`define BC_SPD_MSB 6
`define LED_IDLE_MOD 3
`define LED_CRC_MOD 4
`define LED_REDUCED 5
`define AUX_TEST_LO 6
`define AUX_TEST_HI 7
`define AUX_RGMII_EN 13
`define AUX_RGMII_VAR 12
`define CFG2_SEL 0
// ==========================================================
// Codes
`define SPD_10 2'h0
`define SPD_100 2'h1
`define SPD_1000 2'h2
`define IF_NONE 2'h0
`define IF_MII 2'h1
`define IF_GMII 2'h2
`define IF_RGMII 2'h3
`define OP_WRITE 2'h1
`define OP_READ 2'h2
// ==========================================================
// Timing counts (clk at 125 MHz, 8 ns)
`define CLK_NS 8
`define INIT_NS 1024
`define INIT_CYCLES (`INIT_NS / `CLK_NS)
`define SOFT_NS 512
`define SOFT_CYCLES (`SOFT_NS / `CLK_NS)
`define ERR_HOLD 16'hffff
`define PREAMBLE_MIN 6'h20
`define SLOW_BIT 23
`define FAST_BIT 21
`define TEST_PAT_LEN 8'hff
`define LOOP_DEPTH 4
`endif

// File: core/phy_ctrl.v
// Mode, indicator, MAC interface select, test and interrupt control
`timescale 1ns/1ns
`include "phy_ctrl_consts.vh"
module phy_ctrl (
	input wire clk,
	input wire srst,
	input wire mdc,
	input wire mdioIn,
	output reg mdioOut,
	output reg mdioOe,
	input wire strapSelLo,
	input wire strapSelHi,
	input wire strapMacClkEn,
	input wire strapMacFreq,
	input wire [4:0] strapPhyAddr,
	input wire linkUp,
	input wire [1:0] anSpeed,
	input wire fullDuplex,
	input wire activity,
	input wire idleErr,
	input wire crcErr,
	input wire [15:0] intSrc,
	input wire [7:0] txd,
	input wire txEn,
	input wire txEr,
	input wire [7:0] pcsRxd,
	input wire pcsRxDv,
	input wire pcsRxEr,
	output reg [7:0] mediaTxd,
	output reg mediaTxEn,
	output reg [7:0] rxd,
	output reg rxDv,
	output reg rxEr,
	output reg macOe,
	output reg [1:0] macIfMode,
	output reg rgmiiVariant,
	output reg powerDown,
	output reg macClkRun,
	output reg macClkFast,
	output reg [2:0] testMode,
	output reg testPatternClock,
	output reg testTrigger,
	output reg testAuxClock,
	output reg testOe,
	output reg lowSpeedLinkLamp,
	output reg gigLinkLamp,
	output reg activityLamp,
	output reg duplexLamp,
	output reg intN,
	output reg intOe
);

// ==========================================================
// Input synchronisers
// Management pins and straps pass two flops before any logic reads them
reg [10:0] syncA_r;
reg [10:0] syncB_r;
always @(posedge clk) begin
	syncA_r <= {mdc, mdioIn, strapSelLo, strapSelHi, strapMacClkEn,
		strapMacFreq, strapPhyAddr};
	syncB_r <= syncA_r;
end
wire mdcS = syncB_r[10];
wire mdioS = syncB_r[9];

// ==========================================================
// Strap capture, one cycle after reset release
reg strapTake_r;
reg [8:0] straps_r;
always @(posedge clk) begin
	if (srst) begin
		strapTake_r <= 1'b1;
		straps_r <= 9'h000;
	end else begin
		strapTake_r <= 1'b0;
		if (strapTake_r)
			straps_r <= syncB_r[8:0];
	end
end
wire sSelLo = straps_r[8];
wire sSelHi = straps_r[7];
wire sClkEn = straps_r[6];
wire sClkFreq = straps_r[5];
wire [4:0] sAddr = straps_r[4:0];

// ==========================================================
// Management serial port
localparam ST_IDLE = 2'h0;
localparam ST_HDR = 2'h1;
localparam ST_TA = 2'h2;
localparam ST_DATA = 2'h3;
reg [1:0] state_r;
reg [5:0] cnt_r;
reg [15:0] shift_r;
reg mdcPrev_r;
reg isRead_r;
reg hit_r;
reg [4:0] regAddr_r;
reg wrStb_r;
reg [15:0] wrData_r;
reg [15:0] rdData;
wire mdcRise = mdcS & ~mdcPrev_r;

// Frame walker: preamble, start, op, addresses, turnaround, data
always @(posedge clk) begin
	if (srst) begin
		state_r <= ST_IDLE;
		cnt_r <= 6'h00;
		shift_r <= `ZERO16;
		mdcPrev_r <= mdcS; // Idle clock level, so no false rise on release
		isRead_r <= 1'b0;
		hit_r <= 1'b0;
		regAddr_r <= 5'h00;
		wrStb_r <= 1'b0;
		wrData_r <= `ZERO16;
		mdioOut <= 1'b0;
		mdioOe <= 1'b0;
	end else begin
		mdcPrev_r <= mdcS;
		wrStb_r <= 1'b0;
		if (mdcRise) begin
			case (state_r)
			ST_IDLE: begin
				mdioOe <= 1'b0;
				if (mdioS) begin
					if (cnt_r != `PREAMBLE_MIN)
						cnt_r <= cnt_r + 6'h01;
				end else begin
					// A zero after a full preamble is the first start bit
					if (cnt_r == `PREAMBLE_MIN)
						state_r <= ST_HDR;
					cnt_r <= 6'h00;
				end
			end
			ST_HDR: begin
				shift_r <= {shift_r[14:0], mdioS};
				cnt_r <= cnt_r + 6'h01;
				if (cnt_r == 6'h0c) begin
					isRead_r <= shift_r[10:9] == `OP_READ;
					hit_r <= shift_r[11] && shift_r[8:4] == sAddr &&
						(shift_r[10:9] == `OP_READ ||
						shift_r[10:9] == `OP_WRITE);
					regAddr_r <= {shift_r[3:0], mdioS};
					state_r <= ST_TA;
					cnt_r <= 6'h00;
				end
			end
			ST_TA: begin
				cnt_r <= cnt_r + 6'h01;
				// Read drives zero in the second turnaround bit
				if (cnt_r == 6'h00 && isRead_r && hit_r) begin
					mdioOe <= 1'b1;
					mdioOut <= 1'b0;
					shift_r <= rdData;
				end
				if (cnt_r == 6'h01) begin
					state_r <= ST_DATA;
					cnt_r <= 6'h00;
					if (isRead_r && hit_r) begin
						mdioOut <= shift_r[15];
						shift_r <= {shift_r[14:0], 1'b0};
					end
				end
			end
			ST_DATA: begin
				cnt_r <= cnt_r + 6'h01;
				if (isRead_r) begin
					mdioOut <= shift_r[15];
					shift_r <= {shift_r[14:0], 1'b0};
				end else begin
					shift_r <= {shift_r[14:0], mdioS};
				end
				if (cnt_r == 6'h0f) begin
					state_r <= ST_IDLE;
					cnt_r <= 6'h00;
					if (!isRead_r && hit_r) begin
						wrStb_r <= 1'b1;
						wrData_r <= {shift_r[14:0], mdioS};
					end
				end
			end
			default: begin
				state_r <= ST_IDLE;
				cnt_r <= 6'h00;
			end
			endcase
		end
	end
end

// ==========================================================
// Register file
reg [15:0] basic_r;
reg [15:0] gigCtl_r;
reg [15:0] aux_r;
reg [15:0] led_r;
reg [15:0] flags_r;
reg [15:0] enables_r;
reg [15:0] cfg2_r;
reg [7:0] softCnt_r;
wire wrBasic = wrStb_r && regAddr_r == `REG_BASIC;
wire wrAck = wrStb_r && regAddr_r == `REG_ACK;
wire softBusy = basic_r[`BC_SOFTRST];

// Control registers; soft reset restores defaults and self-clears
always @(posedge clk) begin
	if (srst || (softBusy && softCnt_r == `SOFT_CYCLES)) begin
		basic_r <= `BASIC_RST;
		gigCtl_r <= `ZERO16;
		aux_r <= `ZERO16;
		led_r <= `ZERO16;
		enables_r <= `ZERO16; // R20
		cfg2_r <= `ZERO16;
		softCnt_r <= 8'h00;
	end else begin
		// Strapped address zero isolates from power-up
		if (strapTake_r)
			basic_r[`BC_ISOLATE] <= syncB_r[4:0] == 5'h00;
		if (softBusy)
			softCnt_r <= softCnt_r + 8'h01;
		if (wrBasic)
			basic_r <= wrData_r;
		if (wrStb_r && regAddr_r == `REG_GIGCTL)
			gigCtl_r <= wrData_r;
		if (wrStb_r && regAddr_r == `REG_AUX)
			aux_r <= wrData_r;
		if (wrStb_r && regAddr_r == `REG_LED)
			led_r <= wrData_r;
		if (wrStb_r && regAddr_r == `REG_ENABLES)
			enables_r <= wrData_r; // R22
		if (wrStb_r && regAddr_r == `REG_CFG2)
			cfg2_r <= wrData_r;
	end
end

// Sticky flags: a new event wins over a same-cycle acknowledge
always @(posedge clk) begin
	if (srst)
		flags_r <= `ZERO16; // R20
	else if (wrAck)
		flags_r <= (flags_r & ~wrData_r) | intSrc; // R22
	else
		flags_r <= flags_r | intSrc;
end

// Read mux; acknowledge register always reads zero (self-clearing)
always @* begin
	case (regAddr_r)
	`REG_BASIC: rdData = basic_r;
	`REG_GIGCTL: rdData = gigCtl_r;
	`REG_AUX: rdData = aux_r;
	`REG_LED: rdData = led_r;
	`REG_FLAGS: rdData = flags_r;
	`REG_ENABLES: rdData = enables_r;
	`REG_CFG2: rdData = cfg2_r;
	default: rdData = `ZERO16;
	endcase
end

// ==========================================================
// MAC interface selection
wire anOn = basic_r[`BC_AN_EN];
wire [1:0] forcedSpd = {basic_r[`BC_SPD_MSB], basic_r[`BC_SPD_LSB]};
wire [1:0] spd = anOn ? anSpeed : forcedSpd; // R7 R8
wire strapRgmii = sSelHi; // R9
wire swRgmii = aux_r[`AUX_RGMII_EN]; // R10
wire isolate = basic_r[`BC_ISOLATE]; // R13
wire loopOn = basic_r[`BC_LOOP];
wire pdOn = basic_r[`BC_PDOWN] | (isolate && spd == `SPD_1000); // R15
wire [2:0] tmSel = gigCtl_r[15:13]; // R18
wire tmValid = tmSel != 3'h0 && tmSel <= 3'h4;
reg [1:0] ifNxt;

// At most one interface type, none in isolate or soft reset, none at speed 11 unless RGMII is on; RGMII masks GMII and MII
always @* begin
	if (isolate || softBusy)
		ifNxt = `IF_NONE; // R14 R15
	else if (strapRgmii || swRgmii)
		ifNxt = `IF_RGMII; // R10
	else if (spd == `SPD_1000)
		ifNxt = `IF_GMII; // R7 R8
	else if (spd == `SPD_10 || spd == `SPD_100)
		ifNxt = `IF_MII;
	else
		ifNxt = `IF_NONE; // reserved speed code
end

// ==========================================================
// Data path with loopback through the coding stages
// Loopback latency models the trip into the media sublayer and back
reg [9:0] loopPipe_r [0:`LOOP_DEPTH-1];
integer i;
wire txTake = ~isolate & ~softBusy & ~pdOn; // R14
always @(posedge clk) begin
	if (srst) begin
		for (i = 0; i < `LOOP_DEPTH; i = i + 1)
			loopPipe_r[i] <= 10'h000;
	end else begin
		loopPipe_r[0] <= txTake ? {txEr, txEn, txd} : 10'h000; // R17
		for (i = 1; i < `LOOP_DEPTH; i = i + 1)
			loopPipe_r[i] <= loopPipe_r[i-1];
	end
end
wire [9:0] loopOut = loopPipe_r[`LOOP_DEPTH-1];

always @(posedge clk) begin
	if (srst) begin
		mediaTxd <= 8'h00;
		mediaTxEn <= 1'b0;
		rxd <= 8'h00;
		rxDv <= 1'b0;
		rxEr <= 1'b0;
		macOe <= 1'b0;
		macIfMode <= `IF_NONE;
		rgmiiVariant <= 1'b0;
		powerDown <= 1'b0;
	end else begin
		// No enable reaches the media in loopback, isolate or test mode; data is zeroed in loopback, isolate, soft reset and power down
		mediaTxEn <= txTake & txEn & ~loopOn & ~tmValid; // R16 R14
		mediaTxd <= txTake & ~loopOn ? txd : 8'h00;
		rxd <= loopOn ? loopOut[7:0] : pcsRxd; // R16
		rxDv <= loopOn ? loopOut[8] : pcsRxDv;
		rxEr <= loopOn ? loopOut[9] : pcsRxEr;
		macOe <= ifNxt != `IF_NONE; // R14 R15
		macIfMode <= ifNxt; // R6
		rgmiiVariant <= swRgmii ? aux_r[`AUX_RGMII_VAR] : sSelLo; // R9
		powerDown <= pdOn; // R15
	end
end

// ==========================================================
// Clock to MAC gating
// Held off until init completes; soft reset stops it for its length
reg [7:0] initCnt_r;
wire initDone = initCnt_r == `INIT_CYCLES;
always @(posedge clk) begin
	if (srst) begin
		initCnt_r <= 8'h00;
		macClkRun <= 1'b0;
		macClkFast <= 1'b0;
	end else begin
		if (!initDone)
			initCnt_r <= initCnt_r + 8'h01;
		macClkRun <= sClkEn & initDone & ~softBusy; // R11 R12
		macClkFast <= sClkFreq; // R11
	end
end

// ==========================================================
// Test mode helpers
reg [7:0] patCnt_r;
wire testEn = tmValid & aux_r[`AUX_TEST_LO] & aux_r[`AUX_TEST_HI];
always @(posedge clk) begin
	if (srst || !testEn) begin
		patCnt_r <= 8'h00;
		testMode <= 3'h0;
		testPatternClock <= 1'b0;
		testTrigger <= 1'b0;
		testAuxClock <= 1'b0;
		testOe <= 1'b0;
	end else begin
		patCnt_r <= patCnt_r == `TEST_PAT_LEN ? 8'h00 : patCnt_r + 8'h01;
		testMode <= tmSel; // R18
		testPatternClock <= patCnt_r[0]; // R19
		testAuxClock <= patCnt_r[1]; // R19
		testTrigger <= patCnt_r == 8'h00; // R19
		testOe <= 1'b1;
	end
end

// ==========================================================
// Indicator lamps
reg [23:0] blink_r;
reg [15:0] errHold_r;
wire errHit = (led_r[`LED_IDLE_MOD] & idleErr & (spd == `SPD_1000)) |
	(led_r[`LED_CRC_MOD] & crcErr); // R5
wire reduced = led_r[`LED_REDUCED]; // R1
wire fourInOne = ~cfg2_r[`CFG2_SEL]; // R1
reg lowNxt;
always @* begin
	if (!reduced)
		lowNxt = linkUp && spd == `SPD_10; // R2
	else if (fourInOne)
		lowNxt = linkUp & ~(activity & blink_r[`SLOW_BIT]); // R2
	else
		lowNxt = linkUp; // R2
end
always @(posedge clk) begin
	if (srst) begin
		blink_r <= 24'h000000;
		errHold_r <= 16'h0000;
		lowSpeedLinkLamp <= 1'b0;
		gigLinkLamp <= 1'b0;
		activityLamp <= 1'b0;
		duplexLamp <= 1'b0;
	end else begin
		blink_r <= blink_r + 24'h000001;
		if (errHit)
			errHold_r <= `ERR_HOLD;
		else if (errHold_r != 16'h0000)
			errHold_r <= errHold_r - 16'h0001;
		lowSpeedLinkLamp <= lowNxt;
		gigLinkLamp <= linkUp && spd == `SPD_1000; // R3
		duplexLamp <= linkUp & fullDuplex; // R3
		// Error blink overrides the steady activity light
		if (errHold_r != 16'h0000)
			activityLamp <= blink_r[`FAST_BIT]; // R5
		else
			activityLamp <= activity; // R4
	end
end

// ==========================================================
// Interrupt pin: driven low only while an enabled flag is set
always @(posedge clk) begin
	if (srst) begin
		intN <= 1'b1;
		intOe <= 1'b0; // R20
	end else begin
		intN <= ~|(flags_r & enables_r); // R21 R22
		intOe <= |(flags_r & enables_r); // R21
	end
end

endmodule // phy_ctrl

// File: verification/phy_ctrl_asserts.sv
// Port-level checker for the transceiver control block
`timescale 1ns/1ns
`include "phy_ctrl_consts.vh"
module phy_ctrl_asserts (
	input wire clk,
	input wire srst,
	input wire txEn,
	input wire mediaTxEn,
	input wire powerDown,
	input wire macClkRun,
	input wire macClkFast,
	input wire strapMacClkEn,
	input wire strapMacFreq,
	input wire [2:0] testMode,
	input wire testOe,
	input wire testPatternClock,
	input wire testTrigger,
	input wire testAuxClock,
	input wire gigLinkLamp,
	input wire linkUp,
	input wire intN,
	input wire intOe
);
	// ==========================================================
	// Helper logic
	// Cycles since reset release; saturates so it never wraps
	reg [7:0] upCnt_r;
	always @(posedge clk) begin
		if (srst)
			upCnt_r <= 8'h00;
		else if (upCnt_r != 8'hff)
			upCnt_r <= upCnt_r + 8'h01;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// ==========================================================
	// Assertions
	AST_INT_LOW: assert property (intOe |-> !intN)
		else $error("interrupt driven while high");
	AST_INT_RST: assert property ($past(srst) |-> !intOe && intN)
		else $error("interrupt active right after reset");
	AST_PD_MEDIA: assert property (powerDown && $past(powerDown)
		|-> !mediaTxEn)
		else $error("media transmit while powered down");
	AST_MEDIA_SRC: assert property ($rose(mediaTxEn) |-> $past(txEn))
		else $error("media transmit without MAC enable");
	AST_TEST_CODE: assert property (testOe
		|-> testMode inside {3'h1, 3'h2, 3'h3, 3'h4})
		else $error("test outputs with no test mode");
	AST_TEST_QUIET: assert property (!testOe
		|-> !(testPatternClock || testTrigger || testAuxClock))
		else $error("test helper outputs while disabled");
	AST_CLK_INIT: assert property (macClkRun
		|-> upCnt_r >= `INIT_CYCLES - 1)
		else $error("MAC clock before init done");
	AST_CLK_STRAP: assert property (macClkRun
		|-> strapMacClkEn && macClkFast == strapMacFreq)
		else $error("MAC clock disagrees with straps");
	AST_GIG_LAMP: assert property (gigLinkLamp |-> $past(linkUp))
		else $error("gigabit lamp without link");
	// Main scenarios reached
	cover property ($rose(intOe));
	cover property (testOe);
	cover property (powerDown);
	cover property ($rose(macClkRun));
endmodule // phy_ctrl_asserts
bind phy_ctrl phy_ctrl_asserts phy_ctrl_asserts_i (.clk, .srst, .txEn,
	.mediaTxEn, .powerDown, .macClkRun, .macClkFast, .strapMacClkEn,
	.strapMacFreq, .testMode, .testOe, .testPatternClock, .testTrigger,
	.testAuxClock, .gigLinkLamp, .linkUp, .intN, .intOe);

// File: verification/mac_model.sv
// Behavioural MAC transmit side feeding the control block
`timescale 1ns/1ns
module mac_model (
	input wire clk,
	input wire go,
	output reg [7:0] txd,
	output reg txEn,
	output reg txEr
);
	reg [1:0] k;
	initial begin
		txd = 8'h00;
		txEn = 1'b0;
		txEr = 1'b0;
		k = 2'h0;
	end
	// Four-byte burst per request; idle data toggles so a stale
	// byte can never pass for a fresh one
	always @(posedge clk) begin
		if (k != 2'h0 || go) begin
			txEn <= 1'b1;
			txd <= 8'ha5 + {6'h00, k};
			k <= k + 2'h1;
		end else begin
			txEn <= 1'b0;
			txd <= ~txd;
		end
	end
endmodule // mac_model

// File: verification/testbench.sv
// Self-checking bench for the transceiver control block
`timescale 1ns/1ns
`include "phy_ctrl_consts.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
	$display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module testbench;
	reg clk, srst, mdc, mdBit, go, dv, med;
	reg strapSelLo, strapSelHi, strapMacClkEn, strapMacFreq;
	reg linkUp, fullDuplex, activity, idleErr, crcErr;
	reg pcsRxDv, pcsRxEr;
	reg [4:0] strapPhyAddr;
	reg [1:0] anSpeed;
	reg [15:0] intSrc, rdv, got;
	reg [7:0] pcsRxd, first;
	wire [7:0] txd, mediaTxd, rxd;
	wire [1:0] macIfMode;
	wire [2:0] testMode;
	wire mdioIn, mdioOut, mdioOe, txEn, txEr, mediaTxEn, rxDv, rxEr;
	wire macOe, rgmiiVariant, powerDown, macClkRun, macClkFast;
	wire testPatternClock, testTrigger, testAuxClock, testOe;
	wire lowSpeedLinkLamp, gigLinkLamp, activityLamp, duplexLamp;
	wire intN, intOe;
	int n_fail = 0;
	int n_tests = 0;
	int c;
	// Pulled-up management line: device wins while it drives
	assign mdioIn = mdioOe ? mdioOut : mdBit;
	phy_ctrl phy_ctrl_i (.clk, .srst, .mdc, .mdioIn, .mdioOut, .mdioOe,
		.strapSelLo, .strapSelHi, .strapMacClkEn, .strapMacFreq,
		.strapPhyAddr, .linkUp, .anSpeed, .fullDuplex, .activity,
		.idleErr, .crcErr, .intSrc, .txd, .txEn, .txEr, .pcsRxd,
		.pcsRxDv, .pcsRxEr, .mediaTxd, .mediaTxEn, .rxd, .rxDv, .rxEr,
		.macOe, .macIfMode, .rgmiiVariant, .powerDown, .macClkRun,
		.macClkFast, .testMode, .testPatternClock, .testTrigger,
		.testAuxClock, .testOe, .lowSpeedLinkLamp, .gigLinkLamp,
		.activityLamp, .duplexLamp, .intN, .intOe);
	mac_model mac_model_i (.clk, .go, .txd, .txEn, .txEr);
	// ==========================================================
	// Tasks
	task stop_test;
		$display("Checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	// One management bit, eight clocks; line sampled before the rise
	task mbit(input b);
		mdBit = b;
		mdc = 1'b0;
		tick(4);
		rdv = {rdv[14:0], mdioIn};
		mdc = 1'b1;
		tick(4);
	endtask
	// Whole frame with preamble; a read releases turnaround and data
	task frame(input [1:0] op, input [4:0] ra, input [15:0] wd);
		reg [31:0] f;
		f = {2'b01, op, strapPhyAddr, ra, 2'b10, wd};
		if (op == `OP_READ)
			f[17:0] = 18'h3ffff;
		repeat (32) mbit(1'b1);
		for (int j = 31; j >= 0; j--)
			mbit(f[j]);
		got = rdv;
		mbit(1'b1);
	endtask
	task wr(input [4:0] ra, input [15:0] d);
		frame(`OP_WRITE, ra, d);
	endtask
	task rdc(input [4:0] ra, input [15:0] e);
		frame(`OP_READ, ra, 16'h0000);
		`CHK(got, e)
	endtask
	// Partner burst; both directions watched for a fixed 16 clocks
	task burst;
		dv = 1'b0;
		med = 1'b0;
		first = 8'h00;
		go = 1'b1;
		tick(1);
		go = 1'b0;
		repeat (16) begin
			tick(1);
			if (mediaTxEn === 1'b1)
				med = 1'b1;
			if (rxDv === 1'b1 && !dv) begin
				dv = 1'b1;
				first = rxd;
			end
		end
	endtask
	// ==========================================================
	// Clock and watchdog
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		#800000;
		n_fail++;
		stop_test;
	end
	// ==========================================================
	// Main sequence
	initial begin
		{srst, mdc, mdBit, go} = 4'hf;
		{strapSelLo, strapSelHi, strapMacClkEn, strapMacFreq} = 4'h3;
		strapPhyAddr = 5'h01;
		{linkUp, fullDuplex, activity, idleErr, crcErr} = 5'h18;
		{pcsRxDv, pcsRxEr, pcsRxd} = {2'b10, 8'h3c};
		anSpeed = `SPD_1000;
		intSrc = 16'h0000;
		go = 1'b0;
		tick(6);
		srst = 1'b0;
		tick(2);
		`CHK(macClkRun, 1'b0)
		`CHK(intOe, 1'b0)
		rdc(`REG_BASIC, `BASIC_RST);
		rdc(`REG_ENABLES, `ZERO16);
		rdc(`REG_FLAGS, `ZERO16);
		rdc(5'h1f, `ZERO16);
		`CHK({macClkRun, macClkFast}, 2'b11)
		for (c = 0; c < 3; c++) begin
			anSpeed = c[1:0];
			tick(3);
			`CHK(macIfMode, c == 2 ? `IF_GMII : `IF_MII)
		end
		for (c = 0; c < 4; c++) begin
			wr(`REG_BASIC, {2'b00, c[0], 6'h00, c[1], 6'h00});
			`CHK(macIfMode, c == 3 ? `IF_NONE : c == 2 ? `IF_GMII : `IF_MII)
		end
		wr(`REG_BASIC, `BASIC_RST);
		wr(`REG_AUX, 16'h2000);
		`CHK({macIfMode, rgmiiVariant}, 3'h6)
		wr(`REG_AUX, 16'h3000);
		`CHK({macIfMode, rgmiiVariant}, 3'h7)
		wr(`REG_AUX, `ZERO16);
		`CHK(lowSpeedLinkLamp, 1'b0)
		wr(`REG_LED, 16'h0020);
		wr(`REG_CFG2, 16'h0001);
		activity = 1'b1;
		tick(3);
		`CHK({lowSpeedLinkLamp, gigLinkLamp, duplexLamp}, 3'h7)
		`CHK(activityLamp, 1'b1)
		wr(`REG_LED, `ZERO16);
		anSpeed = `SPD_10;
		tick(3);
		`CHK(lowSpeedLinkLamp, 1'b1)
		// A CRC error with modulation off leaves the lamp steady
		crcErr = 1'b1;
		tick(1);
		crcErr = 1'b0;
		tick(3);
		`CHK(activityLamp, 1'b1)
		// Fast blink phase is still dark this early after reset
		wr(`REG_LED, 16'h0010);
		crcErr = 1'b1;
		tick(1);
		crcErr = 1'b0;
		tick(3);
		`CHK(activityLamp, 1'b0)
		{activity, anSpeed} = {1'b0, `SPD_1000};
		burst;
		`CHK({dv, med, first}, {2'b11, 8'h3c})
		wr(`REG_BASIC, 16'h5140);
		burst;
		`CHK({dv, med, first}, {2'b10, 8'ha5})
		wr(`REG_BASIC, 16'h1540);
		burst;
		`CHK({med, macOe, macIfMode, powerDown}, 5'h01)
		// Forced 10M isolate: outputs float, no power down
		wr(`REG_BASIC, 16'h0400);
		burst;
		`CHK({med, macOe, macIfMode, powerDown}, 5'h00)
		wr(`REG_BASIC, `BASIC_RST);
		wr(`REG_AUX, 16'h00c0);
		for (c = 1; c < 5; c++) begin
			wr(`REG_GIGCTL, {c[2:0], 13'h0000});
			`CHK({testMode, testOe}, {c[2:0], 1'b1})
		end
		wr(`REG_AUX, `ZERO16);
		`CHK(testOe, 1'b0)
		wr(`REG_ENABLES, 16'h0001);
		intSrc = 16'h0003;
		tick(1);
		intSrc = 16'h0000;
		tick(3);
		`CHK({intN, intOe}, 2'b01)
		rdc(`REG_FLAGS, 16'h0003);
		wr(`REG_ACK, 16'h0001);
		`CHK({intN, intOe}, 2'b10)
		rdc(`REG_FLAGS, 16'h0002);
		rdc(`REG_ACK, `ZERO16);
		{strapSelLo, strapSelHi, strapMacFreq} = 3'h6;
		srst = 1'b1;
		tick(6);
		srst = 1'b0;
		tick(3);
		`CHK({macIfMode, rgmiiVariant}, 3'h7)
		rdc(`REG_FLAGS, `ZERO16);
		`CHK(macClkFast, 1'b0)
		stop_test;
	end
endmodule // testbench
